/* File: rtl/lbx_map.svh */
// constants, opcode fields and timing for the logic/bit/skip/call execution unit
// Overview of operation
// - and_immediate_op ANDs working register with 8-bit literal, result to W, zero flag only.
// - and_file_op ANDs working register with file register 0..31, updates zero flag.
// - and_file_op destination bit 0 writes W, destination bit 1 writes the file register.
// - bit_set_op sets chosen bit 0..7 of file register, other bits and flags unchanged.
// - test_skip_clear_op skips next instruction when chosen bit is zero, flags unchanged.
// - test_skip_set_op skips next instruction when chosen bit is one, flags unchanged.
// - taken skip discards prefetched word, runs no_operation, two cycles total.
// - clear_work_op loads W with 00h and sets the zero flag.
// - call pushes its own address plus 1 (program_counter during the call) onto return stack before jumping.
// - call loads pc 7:0 from literal, 10:9 from status 6:5, bit 8 zero.
// - call takes two cycles and leaves all status flags unchanged.
`ifndef LBX_MAP_SVH
`define LBX_MAP_SVH
`define LBX_OP_NOP 12'h000
`define LBX_OP_CLEAR_WORK 12'h040
`define LBX_OPC4_AND_IMM 4'hE
`define LBX_OPC4_CALL 4'h9
`define LBX_OPC4_BIT_SET 4'h5
`define LBX_OPC4_SKIP_CLR 4'h6
`define LBX_OPC4_SKIP_SET 4'h7
`define LBX_OPC6_AND_FILE 6'h05
`define LBX_STATUS_ADDR 5'h03
`define LBX_ZERO_BIT 2
`define LBX_PAGE_LO 5
`define LBX_PAGE_HI 6
`define LBX_RESET_PC 11'h7FF
`define LBX_RESET_W 8'h00
`define LBX_RESET_STATUS 8'h18
`define LBX_RESET_FILE 8'h00
`define LBX_STACK_DEPTH 2
`endif

/* File: rtl/lbx_pkg.sv */
// shared types for the execution unit
package lbx_pkg;
  typedef enum logic [2:0] {
    LBX_NOP, LBX_AND_IMM, LBX_AND_FILE, LBX_BIT_SET, LBX_SKIP_CLR, LBX_SKIP_SET,
    LBX_CLR_W, LBX_CALL
  } lbx_kind_t;
  typedef struct packed {
    lbx_kind_t kind;
    logic [7:0] literal;
    logic [4:0] faddr;
    logic [2:0] bitpos;
    logic dest;
  } lbx_dec_t;
endpackage

/* File: rtl/lbx_file_mem.sv */
// file register array with a registered read port and one write port
`timescale 1ns/1ps
`default_nettype none
`include "lbx_map.svh"
module lbx_file_mem #(
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // write-through keeps a back-to-back read of the same address coherent
  always_comb begin
    rdata_nxt = mem_r[raddr];
    if (we && (waddr == raddr)) begin
      rdata_nxt = wdata;
    end
  end
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_r <= `LBX_RESET_FILE;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_cell
      always_ff @(posedge clock) begin
        if (srst) begin
          mem_r[g] <= `LBX_RESET_FILE;
        end else if (we && (waddr == AW'(g))) begin
          mem_r[g] <= wdata;
        end
      end
    end
  endgenerate
  assign rdata = rdata_r;
endmodule // lbx_file_mem
`default_nettype wire

/* File: rtl/lbx_decode.sv */
// instruction word decoder for the supported operations
`timescale 1ns/1ps
`default_nettype none
`include "lbx_map.svh"
module lbx_decode (
  input wire logic [11:0] word,
  output lbx_pkg::lbx_dec_t dec
);
  always_comb begin
    dec.literal = word[7:0];
    dec.faddr = word[4:0];
    dec.bitpos = word[7:5];
    dec.dest = word[5];
    dec.kind = lbx_pkg::LBX_NOP;
    if (word == `LBX_OP_CLEAR_WORK) begin
      dec.kind = lbx_pkg::LBX_CLR_W;
    end else if (word[11:6] == `LBX_OPC6_AND_FILE) begin
      dec.kind = lbx_pkg::LBX_AND_FILE;
    end else if (word[11:8] == `LBX_OPC4_AND_IMM) begin
      dec.kind = lbx_pkg::LBX_AND_IMM;
    end else if (word[11:8] == `LBX_OPC4_CALL) begin
      dec.kind = lbx_pkg::LBX_CALL;
    end else if (word[11:8] == `LBX_OPC4_BIT_SET) begin
      dec.kind = lbx_pkg::LBX_BIT_SET;
    end else if (word[11:8] == `LBX_OPC4_SKIP_CLR) begin
      dec.kind = lbx_pkg::LBX_SKIP_CLR;
    end else if (word[11:8] == `LBX_OPC4_SKIP_SET) begin
      dec.kind = lbx_pkg::LBX_SKIP_SET;
    end
  end
endmodule // lbx_decode
`default_nettype wire

/* File: rtl/lbx_core.sv */
// execution core: fetch, operand read, execute for the and/bit/skip/call subset
`timescale 1ns/1ps
`default_nettype none
`include "lbx_map.svh"
module lbx_core #(
  parameter int PC_W = 11,
  parameter int STACK_DEPTH = `LBX_STACK_DEPTH
) (
  input wire logic clock,
  input wire logic srst,
  output logic [PC_W-1:0] program_counter,
  input wire logic [11:0] instr_word,
  output logic [7:0] work_reg,
  output logic [7:0] status_reg,
  output logic [PC_W-1:0] stack_top,
  output logic exec_valid
);
  typedef enum logic [1:0] {ST_FETCH, ST_EXEC, ST_FLUSH} lbx_state_t;

  lbx_state_t state_r, state_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [7:0] w_r, w_nxt;
  logic [7:0] status_r, status_nxt;
  logic [11:0] ir_r, ir_nxt;
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic [PC_W-1:0] stack_nxt [STACK_DEPTH];
  logic valid_r, valid_nxt;
  lbx_pkg::lbx_dec_t dec;
  logic [7:0] fdata;
  logic [7:0] operand;
  logic [7:0] and_res;
  logic fwe;
  logic [7:0] fwdata;
  logic [PC_W-1:0] pc_inc;

  function automatic logic zero_of(input logic [7:0] v);
    return (v == 8'h00);
  endfunction

  function automatic logic [7:0] bit_mask(input logic [2:0] pos);
    return 8'h01 << pos;
  endfunction

  lbx_decode u_dec (
    .word(ir_r),
    .dec(dec)
  );

  // status is held here, so reads of its address come from the live copy
  lbx_file_mem #(
    .DEPTH(32),
    .AW(5)
  ) u_mem (
    .clock(clock),
    .srst(srst),
    .raddr(ir_nxt[4:0]),
    .rdata(fdata),
    .we(fwe),
    .waddr(dec.faddr),
    .wdata(fwdata)
  );

  assign operand = (dec.faddr == `LBX_STATUS_ADDR) ? status_r : fdata;
  assign and_res = w_r & (dec.kind == lbx_pkg::LBX_AND_IMM ? dec.literal : operand);
  assign pc_inc = PC_W'(pc_r + 1'b1);

  always_comb begin
    state_nxt = state_r;
    pc_nxt = pc_r;
    w_nxt = w_r;
    status_nxt = status_r;
    ir_nxt = ir_r;
    valid_nxt = 1'b0;
    fwe = 1'b0;
    fwdata = and_res;
    for (int i = 0; i < STACK_DEPTH; i++) begin
      stack_nxt[i] = stack_r[i];
    end
    unique case (state_r)
      ST_FETCH: begin
        ir_nxt = instr_word;
        pc_nxt = pc_inc;
        state_nxt = ST_EXEC;
      end
      ST_EXEC: begin
        valid_nxt = 1'b1;
        ir_nxt = instr_word;
        pc_nxt = pc_inc;
        unique case (dec.kind)
          lbx_pkg::LBX_AND_IMM: begin
            w_nxt = and_res;
            status_nxt[`LBX_ZERO_BIT] = zero_of(and_res);
          end
          lbx_pkg::LBX_AND_FILE: begin
            status_nxt[`LBX_ZERO_BIT] = zero_of(and_res);
            if (dec.dest) begin
              if (dec.faddr == `LBX_STATUS_ADDR) begin
                status_nxt = and_res;
                status_nxt[`LBX_ZERO_BIT] = zero_of(and_res);
              end else begin
                fwe = 1'b1;
              end
            end else begin
              w_nxt = and_res;
            end
          end
          lbx_pkg::LBX_BIT_SET: begin
            fwdata = operand | bit_mask(dec.bitpos);
            if (dec.faddr == `LBX_STATUS_ADDR) begin
              status_nxt = fwdata;
            end else begin
              fwe = 1'b1;
            end
          end
          lbx_pkg::LBX_SKIP_CLR: begin
            if (!operand[dec.bitpos]) begin
              state_nxt = ST_FLUSH;
            end
          end
          lbx_pkg::LBX_SKIP_SET: begin
            if (operand[dec.bitpos]) begin
              state_nxt = ST_FLUSH;
            end
          end
          lbx_pkg::LBX_CLR_W: begin
            w_nxt = `LBX_RESET_W;
            status_nxt[`LBX_ZERO_BIT] = 1'b1;
          end
          lbx_pkg::LBX_CALL: begin
            // push return address; pc_r already points past the call
            stack_nxt[0] = pc_r;
            for (int i = 1; i < STACK_DEPTH; i++) begin
              stack_nxt[i] = stack_r[i-1];
            end
            // target from literal and page bits
            pc_nxt = '0;
            pc_nxt[7:0] = dec.literal;
            pc_nxt[10:9] = status_r[`LBX_PAGE_HI:`LBX_PAGE_LO];
            pc_nxt[8] = 1'b0;
            // second cycle refetches at the target
            state_nxt = ST_FETCH;
          end
          default: begin
          end
        endcase
      end
      ST_FLUSH: begin
        // prefetched word dropped, no_operation slot
        // the slot fetches the word after the skipped one, so the test costs two cycles
        valid_nxt = 1'b1;
        ir_nxt = instr_word;
        pc_nxt = pc_inc;
        state_nxt = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_r <= ST_FETCH;
      pc_r <= `LBX_RESET_PC;
      w_r <= `LBX_RESET_W;
      status_r <= `LBX_RESET_STATUS;
      ir_r <= `LBX_OP_NOP;
      valid_r <= 1'b0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= '0;
      end
    end else begin
      state_r <= state_nxt;
      pc_r <= pc_nxt;
      w_r <= w_nxt;
      status_r <= status_nxt;
      ir_r <= ir_nxt;
      valid_r <= valid_nxt;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= stack_nxt[i];
      end
    end
  end

  assign program_counter = pc_r;
  assign work_reg = w_r;
  assign status_reg = status_r;
  assign stack_top = stack_r[0];
  assign exec_valid = valid_r;
endmodule // lbx_core
`default_nettype wire

/* File: sim/lbx_core_asserts.sv */
// port checks for the execution core
`timescale 1ns/1ps
`default_nettype none
module lbx_core_asserts #(
  parameter int PC_W = 11
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [PC_W-1:0] program_counter,
  input wire logic [11:0] instr_word,
  input wire logic [7:0] work_reg,
  input wire logic [7:0] status_reg,
  input wire logic [PC_W-1:0] stack_top,
  input wire logic exec_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_push;
    !$past(srst) && $changed(stack_top);
  endsequence
  sequence s_go;
    $fell(srst);
  endsequence
  a_reset_state: assert property (s_go |-> program_counter == 11'h7FF && work_reg == 8'h00
    && status_reg == 8'h18 && !exec_valid) else $error("bad state after reset");
  a_exec_start: assert property (s_go |-> !exec_valid ##1 !exec_valid ##1 exec_valid)
    else $error("first execute out of place");
  // w starts at zero and only ands or clears, so it never gains a bit
  a_w_only_clears: assert property (!$past(srst) |-> (work_reg & ~$past(work_reg)) == 8'h00)
    else $error("work register gained a bit");
  a_zero_flag_sets: assert property (!$past(srst) && $changed(status_reg[2])
    |-> status_reg[2] && work_reg == 8'h00) else $error("zero flag cleared");
  a_push_value: assert property (s_push |-> stack_top == $past(program_counter))
    else $error("pushed return address wrong");
  a_push_page: assert property (s_push |-> !program_counter[8]
    && program_counter[10:9] == status_reg[6:5]) else $error("call target page wrong");
  a_call_flags: assert property (s_push |-> $stable(status_reg))
    else $error("call changed status");
  a_call_refetch: assert property (s_push |=> !exec_valid)
    else $error("call not two cycles");
endmodule // lbx_core_asserts
bind lbx_core lbx_core_asserts #(.PC_W(PC_W)) u_asserts (.clock(clock), .srst(srst),
  .program_counter(program_counter), .instr_word(instr_word), .work_reg(work_reg),
  .status_reg(status_reg), .stack_top(stack_top), .exec_valid(exec_valid));
`default_nettype wire

/* File: sim/lbx_prog_mem.sv */
// program memory model answering a fetch in the same cycle
`timescale 1ns/1ps
`default_nettype none
module lbx_prog_mem (
  input wire logic [10:0] addr,
  output logic [11:0] word
);
  logic [11:0] rom [2048];
  // no wait states: the core takes the word in the cycle it shows the address
  assign word = rom[addr];
  task automatic clear();
    foreach (rom[i]) rom[i] = 12'h000;
  endtask
endmodule // lbx_prog_mem
`default_nettype wire

/* File: sim/logic_bit_skip_call_exec_test.sv */
// self-checking bench for the execution core
`timescale 1ns/1ps
`default_nettype none
module logic_bit_skip_call_exec_test;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [10:0] program_counter;
  logic [10:0] stack_top;
  logic [11:0] instr_word;
  logic [7:0] work_reg;
  logic [7:0] status_reg;
  logic exec_valid;
  int fails = 0;
  int cmp_count = 0;
  lbx_core uut (.clock(clock), .srst(srst), .program_counter(program_counter),
    .instr_word(instr_word), .work_reg(work_reg), .status_reg(status_reg),
    .stack_top(stack_top), .exec_valid(exec_valid));
  lbx_prog_mem mem (.addr(program_counter), .word(instr_word));
  initial begin
    forever #10 clock = ~clock;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // reset, then stop right after the n-th executed word lands
  task automatic run(input int n);
    int seen;
    seen = 0;
    srst = 1'b1;
    repeat (3) @(posedge clock);
    #1 srst = 1'b0;
    for (int i = 0; i < 60 && seen < n; i++) begin
      @(posedge clock);
      #1;
      if (exec_valid === 1'b1) seen++;
    end
    check(16'(seen), 16'(n));
  endtask
  task automatic t_and_clear();
    logic [11:0] w [6] = '{12'hEFF, 12'hE00, 12'h040, 12'h143, 12'h163, 12'h169};
    logic [7:0] s [6] = '{8'h1C, 8'h1C, 8'h1C, 8'h1C, 8'h04, 8'h1C};
    for (int i = 0; i < 6; i++) begin
      mem.clear();
      mem.rom[0] = w[i];
      run(2);
      check(status_reg, s[i]);
      check(work_reg, 8'h00);
    end
  endtask
  // skipped words would set status bits 7 and 6
  task automatic t_bits_skip();
    mem.clear();
    mem.rom[0] = 12'h569;
    mem.rom[1] = 12'h769;
    mem.rom[2] = 12'h5E3;
    mem.rom[3] = 12'h649;
    mem.rom[4] = 12'h5C3;
    mem.rom[5] = 12'h669;
    mem.rom[6] = 12'h503;
    mem.rom[7] = 12'h709;
    mem.rom[8] = 12'h523;
    run(10);
    check(status_reg, 8'h1B);
  endtask
  // bit 8 left set would land on 745 and set bit 7; a wrong page would land on a cleared word
  task automatic t_call();
    mem.clear();
    mem.rom[0] = 12'h5A3;
    mem.rom[1] = 12'h5C3;
    mem.rom[2] = 12'h945;
    mem.rom[3] = 12'h523;
    mem.rom[11'h645] = 12'h503;
    mem.rom[11'h745] = 12'h5E3;
    run(5);
    check(status_reg, 8'h79);
    check(stack_top, 11'h003);
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #40000;
    fails++;
    stop_test();
  end
  initial begin
    t_and_clear();
    t_bits_skip();
    t_call();
    stop_test();
  end
endmodule // logic_bit_skip_call_exec_test
`default_nettype wire
